/* design/ppsp_pkg.sv */
package ppsp_pkg;
   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_ADDR = 8'h04;
   localparam logic [7:0] OFF_DATA = 8'h08;
   localparam logic [7:0] OFF_STAT = 8'h0c;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   localparam logic [31:0] ADDR_RESET = 32'h0000_0000;
   // ----------------------------------------
   // Control fields
   // ----------------------------------------
   localparam int CTRL_ON = 15;
   localparam int CTRL_MODE_LO = 8;
   localparam int CTRL_READ_GO = 7;
   localparam int CTRL_SEL_ADDR = 6;
   localparam int CTRL_SEL_POL = 3;
   localparam int CTRL_WR_POL = 1;
   localparam int CTRL_RD_POL = 0;
   localparam logic [31:0] CTRL_WMASK = 32'h0000_834b;
   localparam logic [1:0] MODE_MASTER1 = 2'h3;
   // ----------------------------------------
   // Sizes and timing
   // ----------------------------------------
   localparam int DATA_W = 8;
   localparam int ADDR_PINS = 11;
   localparam int BUF_DEPTH = 4;
   localparam int CLK_PERIOD_NS = 10;
   localparam int STROBE_NS = 20;
   localparam int STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Pin register plus three input stages before a read byte is settled
   localparam int SYNC_LAG = 4;
   localparam int READ_CYC = STROBE_CYC + SYNC_LAG;
   typedef enum logic [1:0] {ST_IDLE, ST_WRITE, ST_READ} ppsp_state_t;
endpackage

/* design/ppsp_pin_level.sv */
`timescale 1ns/1ns
`default_nettype none
module ppsp_pin_level (
   input wire logic active,
   input wire logic polarity,
   input wire logic use_address,
   input wire logic address_bit,
   output logic level
);
   // Address use overrides the polarity entirely
   always_comb begin
      if (use_address) begin
         level = address_bit;
      end else begin
         level = polarity ? active : ~active;
      end
   end
endmodule // ppsp_pin_level
`default_nettype wire

/* design/ppsp_port.sv */
`timescale 1ns/1ns
`default_nettype none
module ppsp_port (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic ce,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic [7:0] port_data_in,
   output logic [7:0] port_data_out,
   output logic port_data_oe_n,
   output logic [10:0] port_addr,
   output logic port_select_pin,
   output logic port_write_pin,
   output logic port_read_pin
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   ppsp_pkg::ppsp_state_t state, next_state;
   logic [31:0] ctrl, next_ctrl;
   logic [11:0] address, next_address;
   logic [7:0] buffer [ppsp_pkg::BUF_DEPTH], next_buffer [ppsp_pkg::BUF_DEPTH];
   logic [1:0] wr_idx, next_wr_idx;
   logic [1:0] rd_idx, next_rd_idx;
   logic [3:0] cnt, next_cnt;
   logic [31:0] next_rdata;
   logic [7:0] next_data_out;
   logic [7:0] sync1, sync2, sync3, data_stable;
   logic sel_level, wr_level, rd_level;
   logic act_sel, act_wr, act_rd;
   logic on, master1, sel_addr, last, last_read;

   assign on = ctrl[ppsp_pkg::CTRL_ON];
   assign master1 = ctrl[ppsp_pkg::CTRL_MODE_LO +: 2] == ppsp_pkg::MODE_MASTER1;
   assign sel_addr = ctrl[ppsp_pkg::CTRL_SEL_ADDR];
   assign last = cnt == 4'(ppsp_pkg::STROBE_CYC - 1);
   // Read strobe held until the driven byte has passed the synchroniser
   assign last_read = cnt == 4'(ppsp_pkg::READ_CYC - 1);

   function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
      hit = a == off;
   endfunction

   // ----------------------------------------
   // Pin input synchroniser
   // ----------------------------------------
   // Bus value taken only once two late stages agree, so a skewed byte never lands
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         sync1 <= 8'h00;
         sync2 <= 8'h00;
         sync3 <= 8'h00;
         data_stable <= 8'h00;
      end else if (ce) begin
         sync1 <= port_data_in;
         sync2 <= sync1;
         sync3 <= sync2;
         if (sync2 == sync3) begin
            data_stable <= sync3;
         end
      end
   end

   // ----------------------------------------
   // Registers and transfer engine
   // ----------------------------------------
   always_comb begin
      next_state = state;
      next_ctrl = ctrl;
      next_address = address;
      next_buffer = buffer;
      next_wr_idx = wr_idx;
      next_rd_idx = rd_idx;
      next_cnt = cnt;
      next_data_out = port_data_out;
      next_rdata = 32'h0000_0000;
      if (reg_wr && hit(reg_addr, ppsp_pkg::OFF_CTRL)) begin
         next_ctrl = reg_wdata & ppsp_pkg::CTRL_WMASK;
      end
      if (reg_wr && hit(reg_addr, ppsp_pkg::OFF_ADDR)) begin
         next_address = reg_wdata[11:0];
      end
      unique case (state)
         ppsp_pkg::ST_IDLE: begin
            next_cnt = 4'h0;
            // Writes while a strobe runs are dropped, not queued
            if (on && reg_wr && hit(reg_addr, ppsp_pkg::OFF_DATA)) begin
               next_buffer[wr_idx] = reg_wdata[7:0];
               next_wr_idx = wr_idx + 2'h1;
               next_data_out = reg_wdata[7:0];
               next_state = ppsp_pkg::ST_WRITE;
            end else if (on && reg_wr && hit(reg_addr, ppsp_pkg::OFF_CTRL)
                         && reg_wdata[ppsp_pkg::CTRL_READ_GO]) begin
               next_state = ppsp_pkg::ST_READ;
            end
         end
         ppsp_pkg::ST_WRITE: begin
            next_cnt = cnt + 4'h1;
            if (last) begin
               next_state = ppsp_pkg::ST_IDLE;
            end
         end
         ppsp_pkg::ST_READ: begin
            next_cnt = cnt + 4'h1;
            if (last_read) begin
               next_buffer[wr_idx] = data_stable;
               next_wr_idx = wr_idx + 2'h1;
               next_state = ppsp_pkg::ST_IDLE;
            end
         end
      endcase
      // Clearing the enable aborts any strobe in flight
      if (!next_ctrl[ppsp_pkg::CTRL_ON]) begin
         next_state = ppsp_pkg::ST_IDLE;
      end
      if (reg_rd) begin
         if (hit(reg_addr, ppsp_pkg::OFF_CTRL)) begin
            next_rdata = ctrl;
         end else if (hit(reg_addr, ppsp_pkg::OFF_ADDR)) begin
            next_rdata = {20'h00000, address};
         end else if (hit(reg_addr, ppsp_pkg::OFF_DATA)) begin
            next_rdata = {24'h000000, buffer[rd_idx]};
            next_rd_idx = rd_idx + 2'h1;
         end else if (hit(reg_addr, ppsp_pkg::OFF_STAT)) begin
            next_rdata = {26'h0000000, state != ppsp_pkg::ST_IDLE, 1'b0, wr_idx, rd_idx};
         end
      end
   end

   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= ppsp_pkg::ST_IDLE;
         ctrl <= ppsp_pkg::CTRL_RESET;
         address <= ppsp_pkg::ADDR_RESET[11:0];
         for (int i = 0; i < ppsp_pkg::BUF_DEPTH; i++) begin
            buffer[i] <= 8'h00;
         end
         wr_idx <= 2'h0;
         rd_idx <= 2'h0;
         cnt <= 4'h0;
         port_data_out <= 8'h00;
         reg_rdata <= 32'h0000_0000;
      end else if (ce) begin
         state <= next_state;
         ctrl <= next_ctrl;
         address <= next_address;
         buffer <= next_buffer;
         wr_idx <= next_wr_idx;
         rd_idx <= next_rd_idx;
         cnt <= next_cnt;
         port_data_out <= next_data_out;
         reg_rdata <= next_rdata;
      end
   end

   // ----------------------------------------
   // Strobe selection and polarity
   // ----------------------------------------
   // Mode 11 turns the write pin into an enable and the read pin into a direction line
   always_comb begin
      act_sel = state != ppsp_pkg::ST_IDLE;
      if (master1) begin
         act_wr = state != ppsp_pkg::ST_IDLE;
         act_rd = state == ppsp_pkg::ST_READ;
      end else begin
         act_wr = state == ppsp_pkg::ST_WRITE;
         act_rd = state == ppsp_pkg::ST_READ;
      end
   end

   ppsp_pin_level u_sel (
      .active(act_sel),
      .polarity(ctrl[ppsp_pkg::CTRL_SEL_POL]),
      .use_address(sel_addr),
      .address_bit(address[11]),
      .level(sel_level)
   );
   ppsp_pin_level u_wr (
      .active(act_wr),
      .polarity(ctrl[ppsp_pkg::CTRL_WR_POL]),
      .use_address(1'b0),
      .address_bit(1'b0),
      .level(wr_level)
   );
   ppsp_pin_level u_rd (
      .active(act_rd),
      .polarity(ctrl[ppsp_pkg::CTRL_RD_POL]),
      .use_address(1'b0),
      .address_bit(1'b0),
      .level(rd_level)
   );

   // Pins lag the state by one cycle so every output leaves a flip-flop
   always_ff @(posedge sys_clk or negedge reset_n) begin
      if (!reset_n) begin
         port_select_pin <= 1'b1;
         port_write_pin <= 1'b1;
         port_read_pin <= 1'b1;
         port_addr <= 11'h000;
         port_data_oe_n <= 1'b1;
      end else if (ce) begin
         port_select_pin <= sel_level;
         port_write_pin <= wr_level;
         port_read_pin <= rd_level;
         port_addr <= address[10:0];
         port_data_oe_n <= state != ppsp_pkg::ST_WRITE;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n || !ce);

   sequence write_start;
      state == ppsp_pkg::ST_IDLE && on && reg_wr && reg_addr == ppsp_pkg::OFF_DATA;
   endsequence
   sequence write_strobe;
      (state == ppsp_pkg::ST_WRITE && ctrl[ppsp_pkg::CTRL_ON]) [*2] ##1 state == ppsp_pkg::ST_IDLE;
   endsequence

   strobe_length_a: assert property (
      write_start |=> write_strobe or
      (state == ppsp_pkg::ST_WRITE ##1 !ctrl[ppsp_pkg::CTRL_ON] && state == ppsp_pkg::ST_IDLE))
      else $error("write strobe length wrong");
   buffer_advance_a: assert property (write_start |=> wr_idx == $past(wr_idx) + 2'h1)
      else $error("buffer index did not advance");
   select_idle_a: assert property (
      $past(state) == ppsp_pkg::ST_IDLE && !$past(sel_addr)
      |-> port_select_pin == !$past(ctrl[ppsp_pkg::CTRL_SEL_POL]))
      else $error("select idle level wrong");
   write_level_a: assert property (
      $past(state) == ppsp_pkg::ST_WRITE && !$past(master1)
      |-> port_write_pin == $past(ctrl[ppsp_pkg::CTRL_WR_POL]))
      else $error("write strobe level wrong");
   enable_level_a: assert property (
      $past(state) != ppsp_pkg::ST_IDLE && $past(master1)
      |-> port_write_pin == $past(ctrl[ppsp_pkg::CTRL_WR_POL]))
      else $error("enable strobe level wrong");
   read_level_a: assert property (
      $past(state) == ppsp_pkg::ST_READ && !$past(master1)
      |-> port_read_pin == $past(ctrl[ppsp_pkg::CTRL_RD_POL]))
      else $error("read strobe level wrong");
   dir_level_a: assert property (
      $past(state) == ppsp_pkg::ST_WRITE && $past(master1)
      |-> port_read_pin == !$past(ctrl[ppsp_pkg::CTRL_RD_POL]))
      else $error("direction strobe level wrong");
   select_addr_a: assert property (
      $past(sel_addr) |-> port_select_pin == $past(address[11]))
      else $error("select pin ignores address");
   drive_write_a: assert property (
      !port_data_oe_n |-> $past(state) == ppsp_pkg::ST_WRITE)
      else $error("data driven outside write");
   rdata_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
      else $error("read data outside read slot");
endmodule // ppsp_port
`default_nettype wire

/* sim/ppsp_peripheral.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------
// Far-side parallel peripheral
// ----------------------------------------
module ppsp_peripheral (
   input wire logic sys_clk,
   input wire logic mode11,
   input wire logic [2:0] pol,
   input wire logic sel_pin,
   input wire logic wr_pin,
   input wire logic rd_pin,
   input wire logic [7:0] bus_out,
   input wire logic bus_oe_n,
   input wire logic [7:0] rd_byte,
   output logic [7:0] bus_in,
   output logic [7:0] last_wr
);
   logic sel, en, rd, wr;
   logic [7:0] drift = 8'h5a;
   assign sel = sel_pin == pol[2];
   assign en = wr_pin == pol[1];
   assign rd = mode11 ? en && rd_pin == pol[0] : rd_pin == pol[0];
   assign wr = mode11 ? en && rd_pin != pol[0] : en;
   // Drives only inside a read strobe; a released bus drifts so stale data never passes
   assign bus_in = (sel && rd) ? rd_byte : drift;
   always @(posedge sys_clk) begin
      drift <= ~bus_in;
      if (sel && wr && !bus_oe_n) begin
         last_wr <= bus_out;
      end
   end
endmodule // ppsp_peripheral
`default_nettype wire

/* sim/tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
   logic sys_clk, reset_n, ce, reg_wr, reg_rd, oe_n, sel_pin, wr_pin, rd_pin, sad, abit;
   logic [7:0] reg_addr, d_in, d_out, rd_byte, last_wr, b;
   logic [31:0] reg_wdata, reg_rdata, rv, ctrl;
   logic [10:0] port_addr;
   logic [2:0] pol;
   logic [1:0] mode, wi, ri;
   logic [7:0] ebuf [4];
   int num_errors, tests_run, seed;
   ppsp_port dut (.sys_clk(sys_clk), .reset_n(reset_n), .ce(ce), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .port_data_in(d_in), .port_data_out(d_out), .port_data_oe_n(oe_n),
      .port_addr(port_addr), .port_select_pin(sel_pin), .port_write_pin(wr_pin),
      .port_read_pin(rd_pin));
   ppsp_peripheral peer (.sys_clk(sys_clk), .mode11(mode == 2'h3), .pol(pol),
      .sel_pin(sel_pin), .wr_pin(wr_pin), .rd_pin(rd_pin), .bus_out(d_out),
      .bus_oe_n(oe_n), .rd_byte(rd_byte), .bus_in(d_in), .last_wr(last_wr));
   // ----------------------------------------
   // Clock, checks, bus cycles
   // ----------------------------------------
   initial begin
      sys_clk = 1'h0;
      forever #5 sys_clk = ~sys_clk;
   end
   task automatic print_verdict();
      if (num_errors == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic check_pins(input logic [2:0] exp);
      logic [2:0] got;
      got = {sel_pin, wr_pin, rd_pin};
      tests_run++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch pins expected %h seen %h", exp, got);
      end
   endtask
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      reg_wr <= w;
      reg_rd <= !w;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'h0;
      reg_rd <= 1'h0;
      #1 rv = reg_rdata;
   endtask
   // Kind 0 idle, 1 write, 2 read; select may carry an address bit instead
   function automatic logic [2:0] exp_pins(input int k, input logic [1:0] m,
         input logic [2:0] p, input logic sa, input logic ab);
      logic s, w, r;
      s = sa ? ab : (k != 0 ? p[2] : ~p[2]);
      w = (m == 2'h3 ? k != 0 : k == 1) ? p[1] : ~p[1];
      r = (k == 2) ? p[0] : ~p[0];
      return {s, w, r};
   endfunction
   task automatic xfer(input int k);
      if (k == 1) bus(1'h1, ppsp_pkg::OFF_DATA, {24'h0, b});
      else bus(1'h1, ppsp_pkg::OFF_CTRL, ctrl | 32'h0000_0080);
      ebuf[wi] = (k == 1) ? b : rd_byte;
      wi++;
      repeat (2) @(posedge sys_clk);
      #1 check_pins(exp_pins(k, mode, pol, sad, abit));
      if (k == 1) check("data out", {24'h0, b}, {23'h0, oe_n, d_out});
      repeat ((k == 2) ? ppsp_pkg::READ_CYC : ppsp_pkg::STROBE_CYC) @(posedge sys_clk);
      #1 check_pins(exp_pins(0, mode, pol, sad, abit));
   endtask
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      seed = 32'h89ca;
      {reset_n, reg_wr, reg_rd, reg_addr, reg_wdata, sad, abit, wi, ri} = '0;
      {ce, pol, mode, rd_byte, b, ctrl} = {1'h1, 53'h0};
      repeat (12) @(posedge sys_clk);
      reset_n <= 1'h1;
      #1 check_pins(3'h7);
      bus(1'h0, ppsp_pkg::OFF_CTRL, 32'h0);
      check("ctrl reset", ppsp_pkg::CTRL_RESET, rv);
      bus(1'h0, 8'h10, 32'h0);
      check("unmapped", 32'h0, rv);
      for (int i = 0; i < 16; i++) begin
         mode = i[1:0];
         pol = (i < 2) ? {3{i[0]}} : 3'($random(seed));
         ctrl = {16'h0, 1'h1, 5'h0, mode, 4'h0, pol[2], 1'h0, pol[1:0]};
         bus(1'h1, ppsp_pkg::OFF_CTRL, ctrl);
         @(posedge sys_clk);
         #1 check_pins(exp_pins(0, mode, pol, 1'h0, 1'h0));
         bus(1'h0, ppsp_pkg::OFF_CTRL, 32'h0);
         check("ctrl", ctrl, rv);
         b = 8'($random(seed));
         xfer(1);
         check("peer byte", {24'h0, b}, {24'h0, last_wr});
         rd_byte = 8'($random(seed));
         xfer(2);
         bus(1'h0, ppsp_pkg::OFF_DATA, 32'h0);
         check("data read", {24'h0, ebuf[ri]}, rv);
         ri++;
         bus(1'h0, ppsp_pkg::OFF_STAT, 32'h0);
         check("indexes", {28'h0, wi, ri}, rv);
      end
      for (int j = 0; j < 2; j++) begin
         {sad, abit, pol, mode} = {1'h1, j[0], ~j[0], 2'h0, 2'h3};
         ctrl = {16'h0000, 8'h83, 1'h0, 1'h1, 2'h0, pol[2], 3'h0};
         bus(1'h1, ppsp_pkg::OFF_CTRL, ctrl);
         bus(1'h1, ppsp_pkg::OFF_ADDR, {20'h0, abit, 11'h5a3 ^ 11'(j)});
         @(posedge sys_clk);
         #1 check("addr pins", {21'h0, 11'h5a3 ^ 11'(j)}, {21'h0, port_addr});
         b = 8'($random(seed));
         xfer(1);
      end
      // Frozen clock enable must swallow a data write
      @(posedge sys_clk);
      ce <= 1'h0;
      bus(1'h1, ppsp_pkg::OFF_DATA, 32'h0000_003c);
      @(posedge sys_clk);
      ce <= 1'h1;
      bus(1'h0, ppsp_pkg::OFF_STAT, 32'h0);
      check("frozen indexes", {28'h0, wi, ri}, rv);
      bus(1'h1, ppsp_pkg::OFF_CTRL, 32'h0);
      // One idle cycle after turning the port off
      @(posedge sys_clk);
      bus(1'h1, ppsp_pkg::OFF_DATA, 32'h0000_00c3);
      repeat (2) @(posedge sys_clk);
      #1 check("off oe", 32'h1, {31'h0, oe_n});
      bus(1'h0, ppsp_pkg::OFF_STAT, 32'h0);
      check("off indexes", {28'h0, wi, ri}, rv);
      print_verdict();
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      num_errors++;
      print_verdict();
   end
endmodule // tb_top
`default_nettype wire
